// file: core/fs_link_pkg.sv
// Shared constants and state type for the slow-side link end
package fs_link_pkg;
    localparam int LINK_W = 16;
    localparam logic [LINK_W-1:0] LINK_RST = 16'h0000;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLAVE,
        ST_HOLD_WAIT,
        ST_MASTER,
        ST_MEM_REQ
    } link_state_t;
endpackage

// file: core/fs_link_end.sv
// Slow-side end of the fast-slow link: strobes, ready, hold and timer relay
// Function
// RQ1: Sixteen-line shared bus carries address, data, command
// RQ2: Partner drives active-low device detect input
// RQ3: Partner fast strobe requests the ISA bus
// RQ4: Partner fast strobe doubles as memory ready
// RQ5: Partner hold acknowledge grants host bus
// RQ6: Timer channel one output goes to partner
// RQ7: Slow strobe asks partner for memory access
// RQ8: Slow strobe doubles as ISA slave ready
// RQ9: Slow hold request while ISA master asks; the code holds it low in ST_SLAVE
// RQ10: Grant ISA bus only after hold acknowledge
`timescale 1ns/10ps
module fs_link_end (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [fs_link_pkg::LINK_W-1:0] link_bus_in,
    output logic [fs_link_pkg::LINK_W-1:0] link_bus_out,
    output logic link_bus_oe,
    input wire logic device_detect_n,
    input wire logic fast_addr_strobe_n,
    input wire logic fast_hold_ack,
    output logic timer_ch1_out,
    output logic slow_addr_strobe_n,
    output logic slow_hold_req,
    input wire logic timer_ch1,
    output logic device_detected,
    input wire logic isa_master_req,
    output logic isa_master_grant,
    input wire logic isa_mem_req,
    input wire logic isa_slave_done,
    input wire logic [fs_link_pkg::LINK_W-1:0] rd_data,
    input wire logic rd_valid,
    output logic rd_ready,
    output logic [fs_link_pkg::LINK_W-1:0] req_word,
    output logic req_valid,
    input wire logic req_ready
);
    import fs_link_pkg::*;

    link_state_t state_ff, nxt_state;
    logic slow_addr_strobe_n_ff, nxt_slow_addr_strobe_n;
    logic [LINK_W-1:0] bus_ff, nxt_bus;
    logic oe_ff, nxt_oe;
    logic t1_ff, nxt_t1;
    logic det_ff, nxt_det;
    logic [LINK_W-1:0] buf_mem [BUF_DEPTH];
    logic [1:0] cnt_ff, nxt_cnt;
    logic wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic fast_strobe;
    logic push, pop;

    assign fast_strobe = !fast_addr_strobe_n;
    // Link words the partner strobes in ST_SLAVE go through the two-entry buffer; a word that arrives while it is full is dropped
    assign push = (state_ff == ST_SLAVE) && fast_strobe && (cnt_ff != 2'(BUF_DEPTH)); // see RQ1
    assign pop = req_valid && req_ready;
    assign req_valid = (cnt_ff != 2'h0);
    assign req_word = buf_mem[rp_ff];
    assign rd_ready = (state_ff == ST_SLAVE) && isa_slave_done;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        if (push) begin
            nxt_wp = !wp_ff;
        end
        if (pop) begin
            nxt_rp = !rp_ff;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_mem[wp_ff] <= link_bus_in;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_slow_addr_strobe_n = 1'b1;
        nxt_bus = bus_ff;
        nxt_oe = 1'b0;
        nxt_t1 = timer_ch1; // see RQ6
        nxt_det = !device_detect_n; // see RQ2
        case (state_ff)
            ST_IDLE: begin
                if (fast_strobe) begin
                    nxt_state = ST_SLAVE; // see RQ3
                end else if (isa_master_req) begin
                    nxt_state = ST_HOLD_WAIT;
                end
            end
            ST_SLAVE: begin
                // Ready back to partner with read data on the link
                if (rd_valid && isa_slave_done) begin
                    nxt_slow_addr_strobe_n = 1'b0; // see RQ8
                    nxt_bus = rd_data; // see RQ1
                    nxt_oe = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_HOLD_WAIT: begin
                if (!isa_master_req) begin
                    nxt_state = ST_IDLE;
                end else if (fast_hold_ack) begin
                    nxt_state = ST_MASTER; // see RQ5
                end
            end
            ST_MASTER: begin
                if (!isa_master_req || !fast_hold_ack) begin
                    nxt_state = ST_IDLE;
                end else if (isa_mem_req) begin
                    nxt_slow_addr_strobe_n = 1'b0; // see RQ7
                    nxt_state = ST_MEM_REQ;
                end
            end
            ST_MEM_REQ: begin
                // Partner ready ends the memory access
                if (fast_strobe || !isa_master_req) begin
                    nxt_state = ST_MASTER; // see RQ4
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            slow_addr_strobe_n_ff <= 1'b1;
            bus_ff <= LINK_RST;
            oe_ff <= 1'b0;
            t1_ff <= 1'b0;
            det_ff <= 1'b0;
            cnt_ff <= 2'h0;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            slow_addr_strobe_n_ff <= nxt_slow_addr_strobe_n;
            bus_ff <= nxt_bus;
            oe_ff <= nxt_oe;
            t1_ff <= nxt_t1;
            det_ff <= nxt_det;
            cnt_ff <= nxt_cnt;
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    assign link_bus_out = bus_ff;
    assign link_bus_oe = oe_ff;
    assign slow_addr_strobe_n = slow_addr_strobe_n_ff;
    assign timer_ch1_out = t1_ff;
    assign device_detected = det_ff;
    // Hold request tracks the master request combinationally outside ST_SLAVE to avoid a lost cycle
    assign slow_hold_req = isa_master_req && (state_ff != ST_SLAVE); // see RQ9
    assign isa_master_grant = (state_ff == ST_MASTER) || (state_ff == ST_MEM_REQ); // see RQ10

    chk_grant_after_ack: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ10
        $rose(isa_master_grant) |-> $past(fast_hold_ack) && $past(isa_master_req))
        else $error("grant without hold acknowledge");
    chk_hold_follows_req: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ9
        (isa_master_req && state_ff == ST_HOLD_WAIT) |-> slow_hold_req)
        else $error("hold request missing");
    chk_timer_relay: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ6
        ##1 timer_ch1_out == $past(timer_ch1))
        else $error("timer output not relayed");
    chk_mem_strobe: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ7
        (state_ff == ST_MASTER && isa_master_req && fast_hold_ack && isa_mem_req)
        |=> !slow_addr_strobe_n && state_ff == ST_MEM_REQ)
        else $error("memory strobe missing");
    chk_slave_ready: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ8
        (state_ff == ST_SLAVE && rd_valid && isa_slave_done)
        |=> !slow_addr_strobe_n && link_bus_oe && link_bus_out == $past(rd_data))
        else $error("slave ready or data wrong");
    chk_strobe_pulse: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ8
        !slow_addr_strobe_n |=> slow_addr_strobe_n)
        else $error("strobe longer than one cycle");
    chk_fast_request: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ3
        (state_ff == ST_IDLE && !fast_addr_strobe_n) |=> state_ff == ST_SLAVE)
        else $error("fast strobe not taken");
    chk_buf_bound: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ1
        cnt_ff <= 2'h2 && !(cnt_ff == 2'h2 && push))
        else $error("buffer overflow");

    // Held words must not move under a stalled receiver
    chk_buf_stable: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ1
        (req_valid && !req_ready) |=> req_valid && $stable(req_word))
        else $error("buffered word changed while stalled");
    chk_mem_ready_exit: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ4
        (state_ff == ST_MEM_REQ && !fast_addr_strobe_n) |=> state_ff == ST_MASTER)
        else $error("memory ready not taken");
    chk_oe_with_ready: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ8
        link_bus_oe |-> !slow_addr_strobe_n)
        else $error("link driven without ready");
    chk_slave_exit: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ8
        (state_ff == ST_SLAVE && rd_valid && isa_slave_done) |=> state_ff == ST_IDLE)
        else $error("slave cycle not ended");
    chk_idle_no_grant: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ10
        (state_ff == ST_IDLE) |-> !isa_master_grant)
        else $error("grant while idle");
    chk_wait_no_grant: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ10
        (state_ff == ST_HOLD_WAIT && !fast_hold_ack) |=> !isa_master_grant)
        else $error("grant before hold acknowledge");
    chk_master_drop: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ10
        (state_ff == ST_MASTER && !fast_hold_ack) |=> state_ff == ST_IDLE)
        else $error("master kept after acknowledge loss");
    chk_slave_hold_mask: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ9
        (state_ff == ST_SLAVE) |-> !slow_hold_req)
        else $error("hold request during slave cycle");
    chk_detect_relay: assert property (@(posedge core_clk) disable iff (!reset_n) // see RQ2
        ##1 device_detected == !$past(device_detect_n))
        else $error("detect not relayed");
endmodule

// file: verif/far_ctrl.sv
// Behavioural fast-side controller facing the link end
`timescale 1ns/10ps
module far_ctrl (
    input wire logic core_clk,
    input wire logic slow_hold_req,
    input wire logic slow_addr_strobe_n,
    input wire logic go,
    input wire logic gnt,
    output logic fast_addr_strobe_n,
    output logic fast_hold_ack
);
    logic rdy_ff = 1'b0;
    initial fast_hold_ack = 1'b0;
    // Stalls the grant while gnt is low
    always @(posedge core_clk) begin
        fast_hold_ack <= slow_hold_req & gnt;
        rdy_ff <= ~slow_addr_strobe_n & fast_hold_ack;
    end
    assign fast_addr_strobe_n = ~(go | rdy_ff);
endmodule

// file: verif/testbench.sv
// Self-checking bench for the slow-side link end
`timescale 1ns/10ps
module testbench;
    import fs_link_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] word = 16'h0000, rd_data = 16'h0000, link_bus_out, req_word, bus;
    logic device_detect_n = 1'b1, timer_ch1 = 1'b0, isa_master_req = 1'b0, isa_mem_req = 1'b0;
    logic isa_slave_done = 1'b0, rd_valid = 1'b0, req_ready = 1'b0, go = 1'b0, gnt = 1'b0;
    logic link_bus_oe, fast_addr_strobe_n, fast_hold_ack, timer_ch1_out, slow_addr_strobe_n;
    logic slow_hold_req, device_detected, isa_master_grant, rd_ready, req_valid;
    int err_total = 0;
    int cmp_count = 0;
    always #5 core_clk = ~core_clk;
    // Resolved link wire
    assign bus = link_bus_oe ? link_bus_out : word;
    far_ctrl fc (.core_clk(core_clk), .slow_hold_req(slow_hold_req), .go(go), .gnt(gnt),
        .slow_addr_strobe_n(slow_addr_strobe_n), .fast_addr_strobe_n(fast_addr_strobe_n),
        .fast_hold_ack(fast_hold_ack));
    fs_link_end uut (.core_clk(core_clk), .reset_n(reset_n), .link_bus_in(bus),
        .link_bus_out(link_bus_out), .link_bus_oe(link_bus_oe), .timer_ch1(timer_ch1),
        .device_detect_n(device_detect_n), .fast_addr_strobe_n(fast_addr_strobe_n),
        .fast_hold_ack(fast_hold_ack), .timer_ch1_out(timer_ch1_out), .rd_data(rd_data),
        .slow_addr_strobe_n(slow_addr_strobe_n), .slow_hold_req(slow_hold_req),
        .device_detected(device_detected), .isa_master_req(isa_master_req),
        .isa_master_grant(isa_master_grant), .isa_mem_req(isa_mem_req), .rd_ready(rd_ready),
        .isa_slave_done(isa_slave_done), .rd_valid(rd_valid), .req_word(req_word),
        .req_valid(req_valid), .req_ready(req_ready));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task wait_slow_addr_strobe_n;
        for (int i = 0; i < 20 && slow_addr_strobe_n !== 1'b0; i++) step(1);
    endtask
    task give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task t_side;
        chk("slow_addr_strobe_n_n", slow_addr_strobe_n, 16'h1);
        chk("grant", isa_master_grant, 16'h0);
        timer_ch1 = 1'b1;
        device_detect_n = 1'b0;
        step(2);
        chk("timer", timer_ch1_out, 16'h1);
        chk("detect", device_detected, 16'h1);
        timer_ch1 = 1'b0;
        step(2);
        chk("timer", timer_ch1_out, 16'h0);
        $display("side test done");
    endtask
    task t_slave;
        // Fourth word meets a full buffer and must be dropped
        for (int i = 0; i < 4; i++) begin
            go = 1'b1;
            word = 16'hA500 + 16'(i);
            step(1);
        end
        go = 1'b0;
        step(1);
        chk("valid", req_valid, 16'h1);
        chk("w1", req_word, 16'hA501);
        req_ready = 1'b1;
        step(1);
        chk("w2", req_word, 16'hA502);
        step(1);
        chk("empty", req_valid, 16'h0);
        req_ready = 1'b0;
        rd_data = 16'h3C5A;
        rd_valid = 1'b1;
        isa_slave_done = 1'b1;
        #1;
        chk("rd_ready", rd_ready, 16'h1);
        step(1);
        rd_valid = 1'b0;
        isa_slave_done = 1'b0;
        wait_slow_addr_strobe_n;
        chk("ready_n", slow_addr_strobe_n, 16'h0);
        chk("bus", bus, 16'h3C5A);
        chk("oe", link_bus_oe, 16'h1);
        step(1);
        chk("ready_n", slow_addr_strobe_n, 16'h1);
        chk("oe_off", link_bus_oe, 16'h0);
        $display("slave test done");
    endtask
    task t_master;
        isa_master_req = 1'b1;
        step(1);
        chk("hold", slow_hold_req, 16'h1);
        step(4);
        chk("early", isa_master_grant, 16'h0);
        gnt = 1'b1;
        step(3);
        chk("grant", isa_master_grant, 16'h1);
        isa_mem_req = 1'b1;
        step(1);
        isa_mem_req = 1'b0;
        wait_slow_addr_strobe_n;
        chk("mem_n", slow_addr_strobe_n, 16'h0);
        step(4);
        chk("regrant", isa_master_grant, 16'h1);
        isa_master_req = 1'b0;
        step(2);
        chk("release", isa_master_grant, 16'h0);
        chk("hold", slow_hold_req, 16'h0);
        $display("master test done");
    endtask
    initial begin
        step(8);
        reset_n = 1'b1;
        t_side;
        t_slave;
        t_master;
        give_verdict;
    end
    initial begin
        #5000;
        err_total++;
        give_verdict;
    end
endmodule
